// [board_pin_model.sv]
// Board-side model of one 8-bit port: pull-ups, external drivers, floating lines
`timescale 1ns/10ps

module board_pin_model (
   input wire logic i_clk,
   input wire logic [7:0] i_out,
   input wire logic [7:0] i_oe,
   input wire logic i_pullup_en,
   input wire logic [7:0] i_ext_mask,
   input wire logic [7:0] i_ext_val,
   output logic [7:0] o_pin
);
   // ------------------------------
   // Undriven line behaviour
   // ------------------------------
   logic [7:0] float_reg = 8'h5a; // Changes each cycle so a stale value never passes

   // Walk the floating pattern
   always @(posedge i_clk) begin
      float_reg <= float_reg + 8'h3b;
   end

   // ------------------------------
   // Resolved pin level
   // ------------------------------
   // External drivers win, e.g. the strap held low around reset
   assign o_pin = (i_ext_mask & i_ext_val)
      | (~i_ext_mask & ((i_oe & i_out) | (~i_oe & (i_pullup_en ? 8'hff : float_reg))));
endmodule

// [pin_reduced_port_bank.sv]
// Port bank of the reduced-pin controller with register port, converter and emulation strap
`timescale 1ns/10ps
`include "port_bank_defines.svh"

module pin_reduced_port_bank #(
   parameter int CONV_CYCLES = 16
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [7:0] i_p0_pin,
   input wire logic [7:0] i_port_one_pin_level,
   input wire logic [7:0] i_p1_periph,
   output logic [7:0] o_p1_out,
   output logic [7:0] o_p1_oe,
   output logic o_p1_pullup_en,
   input wire logic [7:0] i_port_two_pin_level,
   input wire logic [7:0] i_p2_periph,
   output logic [7:0] o_p2_out,
   output logic [7:0] o_p2_oe,
   output logic o_p2_pullup_en,
   input wire logic [7:0] i_port_six_pin_level,
   input wire logic [7:0] i_p6_periph,
   output logic [7:0] o_p6_out,
   output logic [7:0] o_p6_oe,
   output logic o_p6_pullup_en,
   input wire logic i_bus_active,
   input wire logic i_bus_read,
   input wire logic [7:0] i_bus_addr_data,
   output logic [7:0] o_p3_out,
   output logic [7:0] o_p3_oe,
   input wire logic [9:0] i_analog_code,
   output logic o_adc_busy,
   output logic o_on_circuit_emulation_mode_mode
);
   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Address match helper, used for every write strobe and in the assertions
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction

   localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1); // Final count of a conversion

   // Write strobes per register
   wire wr_p1_latch = i_wr && hit(i_addr, `ADDR_P1_LATCH);
   wire wr_p1_direction = i_wr && hit(i_addr, `ADDR_P1_DIRECTION);
   wire wr_p1_fsel = i_wr && hit(i_addr, `ADDR_P1_FSEL);
   wire wr_p2_latch = i_wr && hit(i_addr, `ADDR_P2_LATCH);
   wire wr_p2_direction = i_wr && hit(i_addr, `ADDR_P2_DIRECTION);
   wire wr_p2_fsel = i_wr && hit(i_addr, `ADDR_P2_FSEL);
   wire wr_p6_latch = i_wr && hit(i_addr, `ADDR_P6_LATCH);
   wire wr_p6_direction = i_wr && hit(i_addr, `ADDR_P6_DIRECTION);
   wire wr_p6_fsel = i_wr && hit(i_addr, `ADDR_P6_FSEL);
   wire wr_p3_latch = i_wr && hit(i_addr, `ADDR_P3_LATCH);
   wire wr_p3_drive = i_wr && hit(i_addr, `ADDR_P3_DRIVE);
   wire wr_adc_ctrl = i_wr && hit(i_addr, `ADDR_ADC_CTRL);

   // ----------------------------------------------------------------
   // Port banks with removed pins
   // ----------------------------------------------------------------
   // Read views from each bank
   logic [7:0] p1_level, p1_latch, p1_direction, p1_fsel;
   logic [7:0] p2_level, p2_latch, p2_direction, p2_fsel;
   logic [7:0] p6_level, p6_latch, p6_direction, p6_fsel;

   // Port one, upper nibble removed
   port_bit_bank #(.REMOVED(`P1_REMOVED)) u_port_one (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wr_latch(wr_p1_latch),
      .i_wr_dir(wr_p1_direction),
      .i_wr_fsel(wr_p1_fsel),
      .i_wdata(i_wdata),
      .i_pin(i_port_one_pin_level),
      .i_periph(i_p1_periph),
      .o_level(p1_level),
      .o_latch(p1_latch),
      .o_dir(p1_direction),
      .o_fsel(p1_fsel),
      .o_pin_out(o_p1_out),
      .o_pin_oe(o_p1_oe),
      .o_pullup_en(o_p1_pullup_en)
   );

   // Port two, bits 3 and 5 removed
   port_bit_bank #(.REMOVED(`P2_REMOVED)) u_port_two (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wr_latch(wr_p2_latch),
      .i_wr_dir(wr_p2_direction),
      .i_wr_fsel(wr_p2_fsel),
      .i_wdata(i_wdata),
      .i_pin(i_port_two_pin_level),
      .i_periph(i_p2_periph),
      .o_level(p2_level),
      .o_latch(p2_latch),
      .o_dir(p2_direction),
      .o_fsel(p2_fsel),
      .o_pin_out(o_p2_out),
      .o_pin_oe(o_p2_oe),
      .o_pullup_en(o_p2_pullup_en)
   );

   // Port six, bits 2 and 3 removed
   port_bit_bank #(.REMOVED(`P6_REMOVED)) u_port_six (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wr_latch(wr_p6_latch),
      .i_wr_dir(wr_p6_direction),
      .i_wr_fsel(wr_p6_fsel),
      .i_wdata(i_wdata),
      .i_pin(i_port_six_pin_level),
      .i_periph(i_p6_periph),
      .o_level(p6_level),
      .o_latch(p6_latch),
      .o_dir(p6_direction),
      .o_fsel(p6_fsel),
      .o_pin_out(o_p6_out),
      .o_pin_oe(o_p6_oe),
      .o_pullup_en(o_p6_pullup_en)
   );

   // ----------------------------------------------------------------
   // Analog port digital view
   // ----------------------------------------------------------------
   // Removed analog pins read low
   wire [7:0] p0_level = i_p0_pin & ~`P0_TIED_LOW;

   // ----------------------------------------------------------------
   // Shared address/data port three
   // ----------------------------------------------------------------
   logic [7:0] p3_latch_reg; // Low-speed output latch
   logic [7:0] p3_drive_reg; // 1 = push-pull per bit, 0 = open drain

   // Latch and drive type writes
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         p3_latch_reg <= `RST_LATCH;
         p3_drive_reg <= `RST_DRIVE;
      end else begin
         if (wr_p3_latch) p3_latch_reg <= i_wdata;
         if (wr_p3_drive) p3_drive_reg <= i_wdata;
      end
   end

   // Drive selection: bus read releases, bus write drives, else low-speed use
   wire [7:0] low_speed_io_oe = p3_drive_reg | ~p3_latch_reg;
   wire [7:0] low_speed_io_out = p3_latch_reg & p3_drive_reg;
   wire [7:0] p3_oe_next = i_bus_read ? 8'h00 : (i_bus_active ? 8'hff : low_speed_io_oe);
   wire [7:0] p3_out_next = i_bus_active ? i_bus_addr_data : low_speed_io_out;

   // Registered port three drive
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_p3_out <= 8'h00;
         o_p3_oe <= 8'h00;
      end else begin
         o_p3_out <= p3_out_next;
         o_p3_oe <= p3_oe_next;
      end
   end

   // ----------------------------------------------------------------
   // Analog converter sequencing
   // ----------------------------------------------------------------
   port_bank_pkg::adc_state_t adc_state_reg; // Converter state
   logic [2:0] adc_ch_reg; // Channel of the running conversion
   logic [7:0] adc_cnt_reg; // Cycles spent converting
   logic [9:0] adc_result_reg; // Last completed result

   wire adc_start = wr_adc_ctrl && i_wdata[`ADC_START_BIT];
   wire adc_removed_ch = (adc_ch_reg <= `ADC_LAST_REMOVED_CH);
   wire adc_done = (adc_state_reg == port_bank_pkg::ADC_CONVERT) && (adc_cnt_reg == CONV_LAST);
   wire [9:0] adc_value = adc_removed_ch ? `ADC_FULL_SCALE : i_analog_code;

   // Conversion state machine
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         adc_state_reg <= port_bank_pkg::ADC_IDLE;
         adc_ch_reg <= 3'h0;
         adc_cnt_reg <= 8'h00;
         adc_result_reg <= 10'h000;
         o_adc_busy <= 1'b0;
      end else begin
         case (adc_state_reg)
            port_bank_pkg::ADC_IDLE: begin
               // Start only when idle
               if (adc_start) begin
                  adc_ch_reg <= i_wdata[2:0];
                  adc_cnt_reg <= 8'h00;
                  adc_state_reg <= port_bank_pkg::ADC_CONVERT;
                  o_adc_busy <= 1'b1;
               end
            end
            port_bank_pkg::ADC_CONVERT: begin
               // Count out the conversion, then store the code
               if (adc_done) begin
                  adc_result_reg <= adc_value;
                  adc_state_reg <= port_bank_pkg::ADC_IDLE;
                  o_adc_busy <= 1'b0;
               end else begin
                  adc_cnt_reg <= adc_cnt_reg + 8'h01;
               end
            end
            default: begin
               adc_state_reg <= port_bank_pkg::ADC_IDLE;
               o_adc_busy <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Emulation mode strap
   // ----------------------------------------------------------------
   logic srst_d_reg; // Reset seen one edge earlier
   wire reset_release = srst_d_reg && !i_srst;

   // Strap caught at the first edge after reset release
   always_ff @(posedge i_clk) begin
      srst_d_reg <= i_srst;
      if (i_srst) begin
         o_on_circuit_emulation_mode_mode <= 1'b0;
      end else if (reset_release) begin
         o_on_circuit_emulation_mode_mode <= ~i_port_two_pin_level[`EMU_PIN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Read data path
   // ----------------------------------------------------------------
   logic [7:0] rd_mux; // Selected read value
   wire [7:0] adc_ctrl_view = {o_adc_busy, 4'h0, adc_ch_reg};

   // Read selection, unmapped reads return zero
   always_comb begin
      case (i_addr)
         `ADDR_P0_LEVEL: rd_mux = p0_level;
         `ADDR_P1_LEVEL: rd_mux = p1_level;
         `ADDR_P1_LATCH: rd_mux = p1_latch;
         `ADDR_P1_DIRECTION: rd_mux = p1_direction;
         `ADDR_P1_FSEL: rd_mux = p1_fsel;
         `ADDR_P2_LEVEL: rd_mux = p2_level;
         `ADDR_P2_LATCH: rd_mux = p2_latch;
         `ADDR_P2_DIRECTION: rd_mux = p2_direction;
         `ADDR_P2_FSEL: rd_mux = p2_fsel;
         `ADDR_P3_LATCH: rd_mux = p3_latch_reg;
         `ADDR_P3_DRIVE: rd_mux = p3_drive_reg;
         `ADDR_ADC_CTRL: rd_mux = adc_ctrl_view;
         `ADDR_ADC_RES_LO: rd_mux = adc_result_reg[7:0];
         `ADDR_ADC_RES_HI: rd_mux = {6'h00, adc_result_reg[9:8]};
         `ADDR_EMU_STATUS: rd_mux = {7'h00, o_on_circuit_emulation_mode_mode};
         `ADDR_P6_LEVEL: rd_mux = p6_level;
         `ADDR_P6_LATCH: rd_mux = p6_latch;
         `ADDR_P6_DIRECTION: rd_mux = p6_direction;
         `ADDR_P6_FSEL: rd_mux = p6_fsel;
         default: rd_mux = `RST_BYTE;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rdata <= `RST_BYTE;
      end else begin
         o_rdata <= i_rd ? rd_mux : `RST_BYTE;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_p1_hard_ones: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_rd && (hit(i_addr, `ADDR_P1_LATCH) || hit(i_addr, `ADDR_P1_DIRECTION)
         || hit(i_addr, `ADDR_P1_LEVEL)) |=> o_rdata[7:4] == 4'hf)
      else $error("port one removed bits not read as one");

   a_p1_fsel_zero: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_rd && hit(i_addr, `ADDR_P1_FSEL) |=> o_rdata[7:4] == 4'h0)
      else $error("port one removed select bits not zero");

   a_p2_hard_bits: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_rd && (hit(i_addr, `ADDR_P2_LATCH) || hit(i_addr, `ADDR_P2_DIRECTION))
         |=> (o_rdata & `P2_REMOVED) == `P2_REMOVED)
      else $error("port two removed bits not read as one");

   a_p6_fsel_zero: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_rd && hit(i_addr, `ADDR_P6_FSEL) |=> (o_rdata & `P6_REMOVED) == 8'h00)
      else $error("port six removed select bits not zero");

   a_removed_write_kept: assert property (
      @(posedge i_clk) disable iff (i_srst)
      wr_p6_direction |=> p6_direction == (($past(i_wdata) & ~`P6_REMOVED) | `P6_REMOVED))
      else $error("port six direction write wrong on kept or removed bits");

   a_p0_tied_low: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_rd && hit(i_addr, `ADDR_P0_LEVEL) |=> o_rdata[1:0] == 2'h0
         && o_rdata[7:2] == $past(i_p0_pin[7:2]))
      else $error("analog port digital view wrong");

   a_adc_full_scale: assert property (
      @(posedge i_clk) disable iff (i_srst)
      adc_start && (i_wdata[2:0] <= `ADC_LAST_REMOVED_CH) && !o_adc_busy
         |-> ##[1:300] (!o_adc_busy && adc_result_reg == `ADC_FULL_SCALE))
      else $error("removed channel did not convert to full scale");

   a_p3_bus_release: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_bus_read |=> o_p3_oe == 8'h00)
      else $error("port three driven during bus read");

   a_pullup_hold: assert property (
      @(posedge i_clk) disable iff (i_srst)
      o_p2_pullup_en && !wr_p2_fsel |=> o_p2_pullup_en)
      else $error("pull-up dropped without select write");

   a_pullup_release: assert property (
      @(posedge i_clk) disable iff (i_srst)
      wr_p1_fsel |=> !o_p1_pullup_en ##1 !o_p1_pullup_en)
      else $error("pull-up still on after select write");

   a_on_circuit_emulation_mode_entry: assert property (
      @(posedge i_clk)
      reset_release |=> o_on_circuit_emulation_mode_mode == !$past(i_port_two_pin_level[6]))
      else $error("emulation strap not taken at reset release");

   a_on_circuit_emulation_mode_stable: assert property (
      @(posedge i_clk) disable iff (i_srst)
      !reset_release |=> $stable(o_on_circuit_emulation_mode_mode))
      else $error("emulation mode changed outside reset release");
endmodule

// [port_bank_defines.svh]
// Named constants of the reduced-pin port bank: addresses, masks, reset values
`ifndef PORT_BANK_DEFINES_SVH
`define PORT_BANK_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses on the plain register port
// ----------------------------------------------------------------
`define ADDR_P0_LEVEL 8'h00
`define ADDR_P1_LEVEL 8'h10
`define ADDR_P1_LATCH 8'h11
`define ADDR_P1_DIRECTION 8'h12
`define ADDR_P1_FSEL 8'h13
`define ADDR_P2_LEVEL 8'h20
`define ADDR_P2_LATCH 8'h21
`define ADDR_P2_DIRECTION 8'h22
`define ADDR_P2_FSEL 8'h23
`define ADDR_P3_LATCH 8'h30
`define ADDR_P3_DRIVE 8'h31
`define ADDR_ADC_CTRL 8'h40
`define ADDR_ADC_RES_LO 8'h41
`define ADDR_ADC_RES_HI 8'h42
`define ADDR_EMU_STATUS 8'h50
`define ADDR_P6_LEVEL 8'h60
`define ADDR_P6_LATCH 8'h61
`define ADDR_P6_DIRECTION 8'h62
`define ADDR_P6_FSEL 8'h63

// ----------------------------------------------------------------
// Removed pins per port and tied inputs
// ----------------------------------------------------------------
`define P1_REMOVED 8'hf0
`define P2_REMOVED 8'h28
`define P6_REMOVED 8'h0c
`define P0_TIED_LOW 8'h03
`define EMU_PIN_BIT 3'h6

// ----------------------------------------------------------------
// Analog converter fields and values
// ----------------------------------------------------------------
`define ADC_FULL_SCALE 10'h3ff
`define ADC_START_BIT 3
`define ADC_BUSY_BIT 7
`define ADC_LAST_REMOVED_CH 3'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_LATCH 8'hff
`define RST_DIR 8'hff
`define RST_FSEL 8'h00
`define RST_BYTE 8'h00
`define RST_DRIVE 8'h00

`endif

// [port_bank_pkg.sv]
// Types shared by the reduced-pin port bank
package port_bank_pkg;
   // Converter sequencing states
   typedef enum logic {ADC_IDLE, ADC_CONVERT} adc_state_t;
   // One byte of port data
   typedef logic [7:0] port_byte_t;
endpackage

// [port_bit_bank.sv]
// One 8-bit port: latch, direction, function select, with removed pins hardwired
`timescale 1ns/10ps
`include "port_bank_defines.svh"

module port_bit_bank #(
   parameter logic [7:0] REMOVED = 8'h00
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wr_latch,
   input wire logic i_wr_dir,
   input wire logic i_wr_fsel,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_pin,
   input wire logic [7:0] i_periph,
   output logic [7:0] o_level,
   output logic [7:0] o_latch,
   output logic [7:0] o_dir,
   output logic [7:0] o_fsel,
   output logic [7:0] o_pin_out,
   output logic [7:0] o_pin_oe,
   output logic o_pullup_en
);
   // ----------------------------------------------------------------
   // Per-bit storage; removed bits have no latch, direction or select flops
   // ----------------------------------------------------------------
   // Reset values taken bit by bit
   localparam logic [7:0] LATCH_INIT = `RST_LATCH;
   localparam logic [7:0] DIR_INIT = `RST_DIR;
   localparam logic [7:0] FSEL_INIT = `RST_FSEL;
   genvar b;
   generate
      for (b = 0; b < 8; b = b + 1) begin : g_bit
         if (REMOVED[b]) begin : g_gone
            // Hardwired read values, writes land nowhere
            assign o_level[b] = 1'b1;
            assign o_latch[b] = 1'b1;
            assign o_dir[b] = 1'b1;
            assign o_fsel[b] = 1'b0;
         end else begin : g_kept
            logic latch_reg;
            logic dir_reg;
            logic fsel_reg;
            // Live pin level
            assign o_level[b] = i_pin[b];
            assign o_latch[b] = latch_reg;
            assign o_dir[b] = dir_reg;
            assign o_fsel[b] = fsel_reg;
            // Software writes to the kept bit
            always_ff @(posedge i_clk) begin
               if (i_srst) begin
                  latch_reg <= LATCH_INIT[b];
                  dir_reg <= DIR_INIT[b];
                  fsel_reg <= FSEL_INIT[b];
               end else begin
                  if (i_wr_latch) latch_reg <= i_wdata[b];
                  if (i_wr_dir) dir_reg <= i_wdata[b];
                  if (i_wr_fsel) fsel_reg <= i_wdata[b];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pin drive: direction 0 drives, function select picks peripheral
   // ----------------------------------------------------------------
   wire [7:0] out_next = ((o_fsel & i_periph) | (~o_fsel & o_latch)) & ~REMOVED;
   wire [7:0] oe_next = ~o_dir & ~REMOVED;

   // Registered pin drive and weak pull-up flag
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_pin_out <= 8'h00;
         o_pin_oe <= 8'h00;
         o_pullup_en <= 1'b1;
      end else begin
         o_pin_out <= out_next;
         o_pin_oe <= oe_next;
         if (i_wr_fsel) o_pullup_en <= 1'b0;
      end
   end
endmodule

// [test_pin_reduced_port_bank.sv]
// Self-checking bench of the reduced-pin port bank
`timescale 1ns/10ps
`include "port_bank_defines.svh"

module test_pin_reduced_port_bank;
   // ------------------------------
   // Signals
   // ------------------------------
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic [7:0] i_p0_pin = 8'h00;
   logic i_bus_active = 1'b0;
   logic i_bus_read = 1'b0;
   logic [7:0] i_bus_addr_data = 8'h00;
   logic [7:0] o_p3_out;
   logic [7:0] o_p3_oe;
   logic [9:0] i_analog_code = 10'h000;
   logic o_adc_busy;
   logic o_on_circuit_emulation_mode_mode;
   port_bank_pkg::port_byte_t pin [3]; // Ports one, two, six
   port_bank_pkg::port_byte_t per [3] = '{8'h00, 8'h00, 8'h00};
   port_bank_pkg::port_byte_t ext_m [3] = '{8'h00, 8'h00, 8'h00};
   port_bank_pkg::port_byte_t ext_v [3] = '{8'h00, 8'h00, 8'h00};
   port_bank_pkg::port_byte_t pout [3];
   port_bank_pkg::port_byte_t poe [3];
   logic pu [3];
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   integer seed = 32'h81cc;
   logic [7:0] exp_q [$]; // Expected read data, oldest first
   logic [7:0] msk_q [$];
   logic rd_pend = 1'b0;
   logic [7:0] e, m, v, wl, wd, wf;
   logic [9:0] code;
   logic [2:0] ch;
   localparam logic [7:0] BASE [3] = '{8'h10, 8'h20, 8'h60};
   localparam logic [7:0] REM [3] = '{`P1_REMOVED, `P2_REMOVED, `P6_REMOVED};

   // ------------------------------
   // Clock, design and board
   // ------------------------------
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end

   pin_reduced_port_bank #(.CONV_CYCLES(4)) dut (.i_clk(i_clk), .i_srst(i_srst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_p0_pin(i_p0_pin), .i_port_one_pin_level(pin[0]), .i_p1_periph(per[0]), .o_p1_out(pout[0]),
      .o_p1_oe(poe[0]), .o_p1_pullup_en(pu[0]), .i_port_two_pin_level(pin[1]), .i_p2_periph(per[1]),
      .o_p2_out(pout[1]), .o_p2_oe(poe[1]), .o_p2_pullup_en(pu[1]), .i_port_six_pin_level(pin[2]),
      .i_p6_periph(per[2]), .o_p6_out(pout[2]), .o_p6_oe(poe[2]), .o_p6_pullup_en(pu[2]),
      .i_bus_active(i_bus_active), .i_bus_read(i_bus_read),
      .i_bus_addr_data(i_bus_addr_data), .o_p3_out(o_p3_out), .o_p3_oe(o_p3_oe),
      .i_analog_code(i_analog_code), .o_adc_busy(o_adc_busy), .o_on_circuit_emulation_mode_mode(o_on_circuit_emulation_mode_mode));

   for (genvar k = 0; k < 3; k++) begin : g_board
      board_pin_model board (.i_clk(i_clk), .i_out(pout[k]), .i_oe(poe[k]),
         .i_pullup_en(pu[k]), .i_ext_mask(ext_m[k]), .i_ext_val(ext_v[k]), .o_pin(pin[k]));
   end

   // ------------------------------
   // Compare, bus and closing tasks
   // ------------------------------
   task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch reg at %0t: exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic chk_pin(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch pin at %0t: exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask

   // Read: note expectation, the monitor compares one cycle later
   task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] mk);
      exp_q.push_back(x & mk);
      msk_q.push_back(mk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic do_reset(input logic strap_low);
      ext_m[1] <= 8'h40;
      ext_v[1] <= strap_low ? 8'h00 : 8'h40;
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      repeat (2) @(posedge i_clk);
      ext_m[1] <= 8'h00;
      #1;
      chk_pin({7'h0, strap_low}, {7'h0, o_on_circuit_emulation_mode_mode});
      chk_pin(8'h07, {5'h0, pu[0], pu[1], pu[2]});
      rd(`ADDR_EMU_STATUS, {7'h0, strap_low}, 8'h01);
      $display("test reset strap %0d done", strap_low);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ------------------------------
   // Read monitor and timeout
   // ------------------------------
   always @(posedge i_clk) begin
      if (rd_pend) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         chk_reg(e, o_rdata & m);
      end
      rd_pend <= i_rd;
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      do_reset(1'b1);
      // Each port: removed bits hold their values whatever is written
      for (int k = 0; k < 3; k++) begin
         v = 8'($random(seed));
         ext_m[k] <= 8'hff;
         ext_v[k] <= v;
         per[k] <= 8'($random(seed));
         wl = 8'($random(seed)) & ~REM[k];
         wd = 8'($random(seed)) & ~REM[k];
         wf = 8'($random(seed)) | REM[k];
         repeat (3) @(posedge i_clk);
         rd(BASE[k], (v & ~REM[k]) | REM[k], 8'hff);
         wr(BASE[k] + 8'h01, wl);
         wr(BASE[k] + 8'h02, wd);
         rd(BASE[k] + 8'h01, wl | REM[k], 8'hff);
         rd(BASE[k] + 8'h02, wd | REM[k], 8'hff);
         #1 chk_pin(8'h01, {7'h0, pu[k]});
         wr(BASE[k] + 8'h03, wf);
         rd(BASE[k] + 8'h03, wf & ~REM[k], 8'hff);
         #1 chk_pin(8'h00, {7'h0, pu[k]});
         chk_pin(~wd & ~REM[k], poe[k]);
         chk_pin(((wf & per[k]) | (~wf & wl)) & ~REM[k], pout[k]);
         ext_m[k] <= 8'h00;
         $display("test port %0d done", k);
      end
      do_reset(1'b0);
      // Analog port digital inputs
      i_p0_pin <= 8'hff;
      @(posedge i_clk);
      rd(`ADDR_P0_LEVEL, 8'hff & ~`P0_TIED_LOW, 8'hff);
      // Conversions on both removed channels and one bonded channel
      for (int j = 0; j < 3; j++) begin
         ch = (j == 2) ? 3'h5 : 3'(j);
         code = 10'($random(seed));
         i_analog_code <= code;
         wr(`ADDR_ADC_CTRL, {5'h01, ch});
         #1 chk_pin(8'h01, {7'h0, o_adc_busy});
         n = 0;
         while (o_adc_busy !== 1'b0 && n < 100) begin
            @(posedge i_clk);
            #1 n++;
         end
         // A conversion that never ends counts as a mismatch
         if (n >= 100) begin
            num_errors++;
         end
         if (ch <= `ADC_LAST_REMOVED_CH) begin
            code = `ADC_FULL_SCALE;
         end
         rd(`ADDR_ADC_RES_LO, code[7:0], 8'hff);
         rd(`ADDR_ADC_RES_HI, {6'h0, code[9:8]}, 8'h03);
      end
      $display("test converter done");
      // Port three: push-pull released while the bus reads in
      v = 8'($random(seed));
      wr(`ADDR_P3_LATCH, 8'h00);
      wr(`ADDR_P3_DRIVE, 8'hff);
      i_bus_active <= 1'b1;
      i_bus_addr_data <= v;
      repeat (2) @(posedge i_clk);
      #1 chk_pin(v, o_p3_out);
      chk_pin(8'hff, o_p3_oe);
      i_bus_read <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1 chk_pin(8'h00, o_p3_oe);
      i_bus_read <= 1'b0;
      i_bus_active <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 chk_pin(8'hff, o_p3_oe);
      chk_pin(8'h00, o_p3_out);
      $display("test port three done");
      tally_and_finish();
   end
endmodule
